// file: dv/exvaf_bus_partner.sv
// far-side bus logic model: runs one bus cycle per command, may end it with a transfer error
// assumes go is raised only while the model is idle; outputs change just after sys_clk rises
`timescale 1ns/1ps

module exvaf_bus_partner (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   input  wire logic                  go,
   input  wire exvaf_pkg::exvaf_bus_t cmd,
   input  wire logic                  err,
   input  wire logic [1:0]            wait_n,
   output exvaf_pkg::exvaf_bus_t      bus,
   output logic                       transfer_error_ack_in,
   output logic                       done
);
   import exvaf_pkg::*;

   logic [1:0] cnt_r;
   logic       busy_r;
   logic       term_r;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus <= '0;
         transfer_error_ack_in <= 1'b0;
         cnt_r <= 2'h0;
         busy_r <= 1'b0;
         term_r <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy_r && go) begin
            bus <= exvaf_bus_t'({1'b1, cmd[5:0]});
            cnt_r <= wait_n;
            busy_r <= 1'b1;
         end else if (busy_r && cnt_r != 2'h0) begin
            // wait states: a slow party keeps the cycle open
            cnt_r <= cnt_r - 2'h1;
         end else if (busy_r && !term_r) begin
            transfer_error_ack_in <= err;
            term_r <= 1'b1;
         end else if (term_r) begin
            transfer_error_ack_in <= 1'b0;
            // released fields stop showing the last value
            bus <= exvaf_bus_t'({1'b0, ~bus[5:0]});
            busy_r <= 1'b0;
            term_r <= 1'b0;
            done <= 1'b1;
         end
      end
   end
endmodule

// file: dv/testbench.sv
// self-checking bench: queue model of vectors and fetch addresses against the block
// assumes exvaf_pkg compiled first; partner model ends bus cycles with error acks when p_err is set
`timescale 1ns/1ps
`include "exvaf_defs.svh"

module testbench;
   import exvaf_pkg::*;

   logic                    sys_clk, rst_b, go, p_err, done, transfer_error_ack_in;
   logic                    exe_idle, bus_idle, instr_use, flow_change, branch_discard;
   logic                    exc_req_valid, vec_ack = 1'b0, exc_ready, vec_fetch_req;
   logic                    init_sp_load, init_pc_load, exc_start, fault_external, line_abort;
   logic                    pipe_freeze, exe_idle_req, icache_cancel, dcache_cancel, stack_writes;
   logic [31:0]             vector_table_base, vec_fetch_addr, base;
   logic [31:0]             seed = 32'ha970;
   logic [1:0]              p_wait;
   logic [7:0]              exc_vector;
   logic [`EXVAF_OFS_W-1:0] exc_offset;
   exvaf_bus_t              bus, cmd;
   exvaf_ifault_t           int_fault;
   exvaf_req_t              exc_req;
   int                      fails = 0, checks = 0, cycles = 0, nfetch = 0, n_abort = 0, e;
   int                      exp_q[$];
   logic [31:0]             fetch_q[$];

   exvaf_top u_dut (.sys_clk, .rst_b, .vector_table_base, .bus, .transfer_error_ack_in,
      .int_fault, .exe_idle, .bus_idle, .instr_use, .flow_change, .branch_discard,
      .exc_req_valid, .exc_req, .vec_ack, .exc_ready, .vec_fetch_req, .vec_fetch_addr,
      .init_sp_load, .init_pc_load, .exc_start, .exc_vector, .exc_offset, .fault_external,
      .line_abort, .pipe_freeze, .exe_idle_req, .icache_cancel, .dcache_cancel, .stack_writes);

   exvaf_bus_partner u_far (.sys_clk, .rst_b, .go, .cmd, .err(p_err), .wait_n(p_wait),
      .bus, .transfer_error_ack_in, .done);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // entries 12..14 are computed below
   function automatic int model_vec(input int c, input int n, input int l, input int u);
      int fixed[16] = '{4, 3, 5, 6, 7, 8, 9, 10, 11, 14, 15, 24, 0, 0, 0, 2};
      if (c == 12) return (l == 0) ? 24 : 24 + l;
      if (c == 13) return 32 + n;
      if (c == 14) return (u < 64) ? 15 : u;
      return fixed[c];
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wait_idle;
      int k = 0;
      while ((exp_q.size() != 0 || exc_ready !== 1'b1 || vec_fetch_req !== 1'b0) && k < 60) begin
         @(posedge sys_clk);
         k++;
      end
      check("settle", k < 60, 1'b1);
      repeat (2) @(posedge sys_clk);
   endtask

   // stack code 2 and external code 2 mean not looked at
   task automatic req(input int c, input logic [3:0] n, input logic [2:0] l, input logic [7:0] u);
      int k = 0;
      exc_req_valid <= 1'b1;
      exc_req <= '{cause: exvaf_cause_t'(c), trap_n: n, level: l, user_vec: u};
      @(posedge sys_clk);
      while (exc_ready !== 1'b1 && k < 30) begin
         @(posedge sys_clk);
         k++;
      end
      exp_q.push_back(model_vec(c, n, l, u) + 256 * ((c == 15) ? 2 : 0) + 2048);
      exc_req_valid <= 1'b0;
      wait_idle();
   endtask

   task automatic bus_cycle(input exvaf_bus_t c, input logic err);
      int k = 0;
      cmd <= c;
      p_err <= err;
      p_wait <= 2'(rnd());
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      while (done !== 1'b1 && k < 20) begin
         @(posedge sys_clk);
         k++;
      end
      check("bus done", done, 1'b1);
      repeat (2) @(posedge sys_clk);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end

   // model side: every exception start and every vector fetch is compared
   always @(posedge sys_clk) begin
      if (rst_b === 1'b1) begin
         if (line_abort === 1'b1)
            n_abort++;
         if (exc_start === 1'b1) begin
            check("reserved vector", exc_vector inside {[12:13], [16:23], [48:63]}, 0);
            if (exp_q.size() == 0) begin
               check("exception start", 1'b1, 1'b0);
            end else begin
               e = exp_q.pop_front();
               check("vector", exc_vector, e % 256);
               check("offset", exc_offset, (e % 256) * 4);
               if ((e / 256) % 4 != 2)
                  check("external", fault_external, (e / 256) % 4);
               if (e / 1024 != 2)
                  check("stacking", stack_writes, e / 1024);
               fetch_q.push_back(base + 32'((e % 256) * 4));
            end
         end
         if (vec_ack === 1'b1) begin
            vec_ack <= 1'b0;
            check("sp load", init_sp_load, nfetch == 0);
            check("pc load", init_pc_load, nfetch == 1);
            nfetch <= nfetch + 1;
         end else if (vec_fetch_req === 1'b1 && rnd() % 2 == 0) begin
            if (fetch_q.size() == 0)
               check("fetch", 1'b1, 1'b0);
            else
               check("fetch address", vec_fetch_addr, fetch_q.pop_front());
            vec_ack <= 1'b1;
         end
      end
   end

   initial begin
      rst_b = 1'b0;
      {go, p_err, exe_idle, bus_idle, instr_use, flow_change, branch_discard} = '0;
      {exc_req_valid, p_wait, cmd, int_fault, exc_req} = '0;
      exe_idle = 1'b1;
      bus_idle = 1'b1;
      base = rnd();
      vector_table_base = base;
      fetch_q.push_back(base);
      fetch_q.push_back(base + 32'h4);
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      wait_idle();
      check("reset fetches", nfetch, 2);
      $display("test reset done");

      for (int c = 0; c < 16; c++)
         req(c, 4'(rnd()), 3'(rnd()), 8'(rnd()));
      for (int k = 0; k < 2; k++) begin
         req(12, 4'h0, k ? 3'h7 : 3'h0, 8'h00);
         req(13, k ? 4'hf : 4'h0, 3'h0, 8'h00);
         req(14, 4'h0, 3'h0, k ? 8'hff : 8'h40);
      end
      req(14, 4'h0, 3'h0, 8'h3f);
      $display("test vector map done");

      // data write, byte read, first line beat, needed late beat: all immediate
      exp_q.push_back(2 + 256 + 2048);
      bus_cycle('{1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 1'b1);
      wait_idle();
      exp_q.push_back(2 + 256 + 2048);
      bus_cycle('{1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0}, 1'b1);
      wait_idle();
      exp_q.push_back(2 + 256 + 2048);
      bus_cycle('{1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0}, 1'b1);
      wait_idle();
      exp_q.push_back(2 + 256 + 2048);
      bus_cycle('{1'b1, 1'b0, 1'b0, 1'b1, 2'h2, 1'b1}, 1'b1);
      wait_idle();
      for (int b = 1; b < 4; b++) begin
         int a0;
         a0 = n_abort;
         bus_cycle('{1'b1, 1'b0, 1'b0, 1'b1, 2'(b), 1'b0}, 1'b1);
         check("line abort", n_abort - a0, 1);
      end
      bus_cycle('{1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 1'b0);
      wait_idle();
      $display("test bus error done");

      bus_cycle('{1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0}, 1'b1);
      repeat (6) @(posedge sys_clk);
      exp_q.push_back(2 + 256 + 2048);
      instr_use <= 1'b1;
      @(posedge sys_clk);
      instr_use <= 1'b0;
      wait_idle();
      for (int k = 0; k < 2; k++) begin
         bus_cycle('{1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0}, 1'b1);
         flow_change <= (k == 0);
         branch_discard <= (k == 1);
         @(posedge sys_clk);
         flow_change <= 1'b0;
         branch_discard <= 1'b0;
         repeat (3) @(posedge sys_clk);
         instr_use <= 1'b1;
         @(posedge sys_clk);
         instr_use <= 1'b0;
         wait_idle();
      end
      $display("test prefetch done");

      exe_idle <= 1'b0;
      bus_idle <= 1'b0;
      int_fault <= '{valid: 1'b1, push: 1'b1};
      @(posedge sys_clk);
      int_fault <= '0;
      repeat (4) @(posedge sys_clk);
      check("freeze", pipe_freeze, 1'b1);
      check("icache cancel", icache_cancel, 1'b1);
      check("dcache cancel", dcache_cancel, 1'b1);
      check("idle request", exe_idle_req, 1'b1);
      exp_q.push_back(2 + 1024);
      exe_idle <= 1'b1;
      wait_idle();
      int_fault <= '{valid: 1'b1, push: 1'b0};
      @(posedge sys_clk);
      int_fault <= '0;
      repeat (5) @(posedge sys_clk);
      check("early freeze", pipe_freeze, 1'b0);
      exp_q.push_back(2 + 1024);
      bus_idle <= 1'b1;
      wait_idle();
      $display("test internal fault done");
      give_verdict();
   end
endmodule

// file: verilog/exvaf_defs.svh
// exception vector numbers and table geometry for the access-fault block
// assumes byte-addressed vector table, one 32-bit entry per vector
`ifndef EXVAF_DEFS_SVH
`define EXVAF_DEFS_SVH

`define EXVAF_VEC_INIT_SP    8'h00
`define EXVAF_VEC_INIT_PC    8'h01
`define EXVAF_VEC_ACCESS     8'h02
`define EXVAF_VEC_ADDR_ERR   8'h03
`define EXVAF_VEC_ILLEGAL    8'h04
`define EXVAF_VEC_DIV_ZERO   8'h05
`define EXVAF_VEC_BOUNDS     8'h06
`define EXVAF_VEC_COND_TRAP  8'h07
`define EXVAF_VEC_PRIV       8'h08
`define EXVAF_VEC_TRACE      8'h09
`define EXVAF_VEC_LINE_A     8'h0a
`define EXVAF_VEC_LINE_F     8'h0b
`define EXVAF_VEC_FORMAT     8'h0e
`define EXVAF_VEC_UNINIT     8'h0f
`define EXVAF_VEC_SPURIOUS   8'h18
`define EXVAF_VEC_AUTO_BASE  8'h18
`define EXVAF_VEC_TRAP_BASE  8'h20
`define EXVAF_VEC_USER_BASE  8'h40
`define EXVAF_OFS_SHIFT      2
`define EXVAF_OFS_W          10
`define EXVAF_BEAT_FIRST     2'h0

`endif

// file: verilog/exvaf_pf_fault.sv
// deferred prefetch fault holder
// assumes use and discard refer to the oldest prefetched instruction
`timescale 1ns/1ps

module exvaf_pf_fault (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic capture,
   input  wire logic instr_use,
   input  wire logic discard,
   output logic      pending,
   output logic      raise
);
   import exvaf_pkg::*;

   exvaf_pf_st_t s_r;
   exvaf_pf_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.raise = 1'b0;
      if (s_r.pending && instr_use && !discard) begin
         s_nxt.raise   = 1'b1;
         s_nxt.pending = 1'b0;
      end else if (discard) begin
         s_nxt.pending = 1'b0;
      end
      // a fault on the new stream must survive a discard of the old one
      if (capture) begin
         s_nxt.pending = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pending = s_r.pending;
   assign raise   = s_r.raise;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   chk_discard_drops_fault: assert property (
      discard && !capture |=> !pending && !raise)
      else $error("discarded prefetch fault still pending");

   chk_use_raises_fault: assert property (
      pending && instr_use && !discard |=> raise)
      else $error("used faulted instruction did not raise");

   chk_no_raise_unused: assert property (
      raise |-> $past(pending) && $past(instr_use))
      else $error("prefetch fault raised without use");

endmodule

// file: verilog/exvaf_pkg.sv
// types shared by the exception vector / access-fault block
// assumes exvaf_defs.svh is on the include path
`include "exvaf_defs.svh"

package exvaf_pkg;

   typedef enum logic [3:0] {
      EXVAF_C_ILLEGAL, EXVAF_C_ADDR_ERR, EXVAF_C_DIV_ZERO, EXVAF_C_BOUNDS,
      EXVAF_C_COND_TRAP, EXVAF_C_PRIV, EXVAF_C_TRACE, EXVAF_C_LINE_A,
      EXVAF_C_LINE_F, EXVAF_C_FORMAT, EXVAF_C_UNINIT, EXVAF_C_SPURIOUS,
      EXVAF_C_AUTOVEC, EXVAF_C_SW_TRAP, EXVAF_C_USER_INT, EXVAF_C_ACCESS
   } exvaf_cause_t;

   typedef struct packed {
      exvaf_cause_t cause;
      logic [3:0]   trap_n;
      logic [2:0]   level;
      logic [7:0]   user_vec;
   } exvaf_req_t;

   typedef struct packed {
      logic       active;
      logic       write;
      logic       prefetch;
      logic       line;
      logic [1:0] beat;
      logic       needed;
   } exvaf_bus_t;

   typedef struct packed {
      logic valid;
      logic push;
   } exvaf_ifault_t;

   typedef enum logic [6:0] {
      EXVAF_S_BOOT   = 7'h01,
      EXVAF_S_RST_SP = 7'h02,
      EXVAF_S_RST_PC = 7'h04,
      EXVAF_S_RUN    = 7'h08,
      EXVAF_S_WAIT   = 7'h10,
      EXVAF_S_TAKE   = 7'h20,
      EXVAF_S_VEC    = 7'h40
   } exvaf_state_t;

   typedef struct packed {
      exvaf_state_t st;
      logic [7:0]   vec;
      logic [31:0]  addr;
      logic         ext;
      logic         push;
      logic         fault;
      logic         line_abort;
      logic         exc_start;
   } exvaf_main_st_t;

   typedef struct packed {
      logic pending;
      logic raise;
   } exvaf_pf_st_t;

   function automatic logic [`EXVAF_OFS_W-1:0] exvaf_offset(input logic [7:0] v);
      exvaf_offset = {v, 2'b00};
   endfunction

endpackage

// file: verilog/exvaf_top.sv
// exception vector assignment and access-fault recognition
// assumes bus cycle status and execute-stage signals are synchronous to sys_clk
`timescale 1ns/1ps
`include "exvaf_defs.svh"

module exvaf_top #(
   parameter int ADDR_W = 32
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   input  wire logic [ADDR_W-1:0]    vector_table_base,
   input  wire exvaf_pkg::exvaf_bus_t    bus,
   input  wire logic                 transfer_error_ack_in,
   input  wire exvaf_pkg::exvaf_ifault_t int_fault,
   input  wire logic                 exe_idle,
   input  wire logic                 bus_idle,
   input  wire logic                 instr_use,
   input  wire logic                 flow_change,
   input  wire logic                 branch_discard,
   input  wire logic                 exc_req_valid,
   input  wire exvaf_pkg::exvaf_req_t    exc_req,
   input  wire logic                 vec_ack,
   output logic                      exc_ready,
   output logic                      vec_fetch_req,
   output logic [ADDR_W-1:0]         vec_fetch_addr,
   output logic                      init_sp_load,
   output logic                      init_pc_load,
   output logic                      exc_start,
   output logic [7:0]                exc_vector,
   output logic [`EXVAF_OFS_W-1:0]   exc_offset,
   output logic                      fault_external,
   output logic                      line_abort,
   output logic                      pipe_freeze,
   output logic                      exe_idle_req,
   output logic                      icache_cancel,
   output logic                      dcache_cancel,
   output logic                      stack_writes
);
   import exvaf_pkg::*;

   // the table offset alone needs the full ten bits
   if (ADDR_W < `EXVAF_OFS_W || ADDR_W > 32) begin : g_bad_addr_w
      $error("exvaf_top: ADDR_W must be 10 to 32");
   end

   exvaf_main_st_t s_r;
   exvaf_main_st_t s_nxt;

   logic       bus_err;
   logic       imm_fault;
   logic       late_beat;
   logic       pf_capture;
   logic       pf_pending;
   logic       pf_raise;
   logic [7:0] req_vec;
   logic       wait_done;

   exvaf_vec_map u_map (
      .req    (exc_req),
      .vector (req_vec)
   );

   exvaf_pf_fault u_pf (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .capture   (pf_capture),
      .instr_use (instr_use),
      .discard   (flow_change | branch_discard),
      .pending   (pf_pending),
      .raise     (pf_raise)
   );

   function automatic logic [ADDR_W-1:0] vec_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [7:0]        v);
      vec_addr = base + ADDR_W'(exvaf_offset(v));
   endfunction

   // bus error classification
   always_comb begin
      bus_err    = bus.active && transfer_error_ack_in;
      late_beat  = bus.line && bus.beat != `EXVAF_BEAT_FIRST;
      imm_fault  = bus_err && !bus.prefetch &&
                   (bus.write ||
                    !late_beat ||
                    bus.needed);
      pf_capture = bus_err && bus.prefetch;
   end

   // data faults wait for the bus controller as well as execute
   assign wait_done = exe_idle && (s_r.push || bus_idle);

   always_comb begin
      s_nxt            = s_r;
      s_nxt.exc_start  = 1'b0;
      s_nxt.line_abort = bus_err && !bus.prefetch && !bus.write && late_beat;
      unique case (s_r.st)
         EXVAF_S_BOOT: begin
            s_nxt.addr = vec_addr(vector_table_base, `EXVAF_VEC_INIT_SP);
            s_nxt.st   = EXVAF_S_RST_SP;
         end
         EXVAF_S_RST_SP: begin
            if (vec_ack) begin
               s_nxt.addr = vec_addr(vector_table_base, `EXVAF_VEC_INIT_PC);
               s_nxt.st   = EXVAF_S_RST_PC;
            end
         end
         EXVAF_S_RST_PC: begin
            if (vec_ack) begin
               s_nxt.st = EXVAF_S_RUN;
            end
         end
         EXVAF_S_RUN: begin
            if (imm_fault || pf_raise) begin
               s_nxt.st    = EXVAF_S_TAKE;
               s_nxt.vec   = `EXVAF_VEC_ACCESS;
               s_nxt.ext   = 1'b1;
               s_nxt.push  = 1'b0;
               s_nxt.fault = 1'b1;
               s_nxt.exc_start = 1'b1;
            end else if (int_fault.valid) begin
               s_nxt.st    = EXVAF_S_WAIT;
               s_nxt.vec   = `EXVAF_VEC_ACCESS;
               s_nxt.ext   = 1'b0;
               s_nxt.push  = int_fault.push;
               s_nxt.fault = 1'b1;
            end else if (exc_req_valid) begin
               s_nxt.st    = EXVAF_S_TAKE;
               s_nxt.vec   = req_vec;
               s_nxt.ext   = 1'b0;
               s_nxt.push  = 1'b0;
               s_nxt.fault = exc_req.cause == EXVAF_C_ACCESS;
               s_nxt.exc_start = 1'b1;
            end
         end
         EXVAF_S_WAIT: begin
            if (wait_done) begin
               s_nxt.st        = EXVAF_S_TAKE;
               s_nxt.exc_start = 1'b1;
            end
         end
         EXVAF_S_TAKE: begin
            s_nxt.addr = vec_addr(vector_table_base, s_r.vec);
            s_nxt.st   = EXVAF_S_VEC;
         end
         EXVAF_S_VEC: begin
            if (vec_ack) begin
               s_nxt.st    = EXVAF_S_RUN;
               s_nxt.fault = 1'b0;
               s_nxt.push  = 1'b0;
            end
         end
         default: begin
            s_nxt.st = EXVAF_S_BOOT;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r    <= '0;
         s_r.st <= EXVAF_S_BOOT;
      end else begin
         s_r <= s_nxt;
      end
   end

   logic in_wait;
   logic in_take;
   logic in_vec;

   assign in_wait = s_r.st == EXVAF_S_WAIT;
   assign in_take = s_r.st == EXVAF_S_TAKE;
   assign in_vec  = s_r.st == EXVAF_S_VEC;

   // new requests only when no access fault is competing this cycle
   assign exc_ready      = s_r.st == EXVAF_S_RUN && !imm_fault && !pf_raise && !int_fault.valid;
   assign vec_fetch_req  = s_r.st == EXVAF_S_RST_SP || s_r.st == EXVAF_S_RST_PC || in_vec;
   assign vec_fetch_addr = s_r.addr;
   assign init_sp_load   = s_r.st == EXVAF_S_RST_SP && vec_ack;
   assign init_pc_load   = s_r.st == EXVAF_S_RST_PC && vec_ack;
   assign exc_start      = s_r.exc_start;
   assign exc_vector     = s_r.vec;
   assign exc_offset     = exvaf_offset(s_r.vec);
   assign fault_external = s_r.ext;
   assign line_abort     = s_r.line_abort;
   // push faults freeze at once; data faults freeze once idle is reached
   assign pipe_freeze    = (in_wait && s_r.push) || in_take || in_vec;
   assign exe_idle_req   = in_wait || (in_take && s_r.fault);
   assign icache_cancel  = s_r.fault && ((in_wait && s_r.push) || in_take);
   // writes are held, not dropped, so the data cache request can go
   assign dcache_cancel  = s_r.push && (in_wait || in_take);
   assign stack_writes   = s_r.fault && !s_r.ext && in_take;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   chk_vec_address: assert property (
      in_take |=> vec_fetch_addr == $past(vector_table_base) + ADDR_W'({s_r.vec, 2'b00}))
      else $error("vector address not base plus four times vector");

   chk_reset_order: assert property (
      init_sp_load |=> s_r.st == EXVAF_S_RST_PC &&
         vec_fetch_addr == $past(vector_table_base) + ADDR_W'(4))
      else $error("reset did not move to initial PC vector");

   chk_no_reserved: assert property (
      exc_start |-> !(exc_vector inside {8'h0c, 8'h0d, [8'h10:8'h17], [8'h30:8'h3f]}))
      else $error("reserved vector generated");

   chk_write_err_now: assert property (
      s_r.st == EXVAF_S_RUN && bus_err && bus.write && !bus.prefetch
      |=> exc_start && exc_vector == `EXVAF_VEC_ACCESS && fault_external)
      else $error("write bus error not taken at once");

   chk_late_beat_abort: assert property (
      bus_err && !bus.write && !bus.prefetch && late_beat |=> line_abort)
      else $error("late line beat error did not abort");

   chk_unneeded_beat: assert property (
      s_r.st == EXVAF_S_RUN && bus_err && late_beat && !bus.write && !bus.needed &&
      !bus.prefetch && !pf_raise && !int_fault.valid && !exc_req_valid
      |=> !exc_start)
      else $error("unneeded line beat raised fault");

   chk_prefetch_defer: assert property (
      s_r.st == EXVAF_S_RUN && bus_err && bus.prefetch && !pf_pending && !pf_raise &&
      !int_fault.valid && !exc_req_valid |=> !exc_start)
      else $error("prefetch error taken before use");

   chk_data_wait_idle: assert property (
      in_wait && !s_r.push && !bus_idle |=> in_wait && !pipe_freeze)
      else $error("data fault taken while bus busy");

   chk_push_freeze: assert property (
      in_wait && s_r.push |-> pipe_freeze && icache_cancel && dcache_cancel)
      else $error("push fault did not freeze and cancel");

   chk_take_to_fetch: assert property (
      exc_start |-> in_take ##1 in_vec && vec_fetch_req)
      else $error("exception did not reach vector fetch");

   chk_one_start: assert property (
      exc_start |=> !exc_start)
      else $error("exception start longer than one cycle");

   chk_pc_then_run: assert property (
      init_pc_load |=> s_r.st == EXVAF_S_RUN && !vec_fetch_req)
      else $error("reset did not resume after initial PC");

   chk_read_err_now: assert property (
      s_r.st == EXVAF_S_RUN && bus_err && !bus.write && !bus.prefetch && !late_beat
      |=> exc_start && exc_vector == `EXVAF_VEC_ACCESS && fault_external)
      else $error("read bus error not taken at once");

   chk_needed_beat: assert property (
      s_r.st == EXVAF_S_RUN && bus_err && late_beat && bus.needed && !bus.prefetch
      |=> exc_start && fault_external)
      else $error("needed line beat error not taken");

   chk_used_fault_taken: assert property (
      s_r.st == EXVAF_S_RUN && pf_raise |=> exc_start && exc_vector == `EXVAF_VEC_ACCESS)
      else $error("used prefetch fault not taken");

   chk_push_holds_wait: assert property (
      in_wait && s_r.push && !exe_idle |=> in_wait)
      else $error("push fault taken before execute idle");

   chk_idle_then_take: assert property (
      in_wait && wait_done |=> exc_start && stack_writes && !fault_external)
      else $error("internal fault not taken once idle");

   chk_data_take_cancel: assert property (
      in_take && s_r.fault && !s_r.push |-> pipe_freeze && icache_cancel && !dcache_cancel)
      else $error("data fault take did not freeze and cancel");

endmodule

// file: verilog/exvaf_vec_map.sv
// cause to vector number decode, purely combinational
// assumes the cause fields are stable while the request is presented
`timescale 1ns/1ps
`include "exvaf_defs.svh"

module exvaf_vec_map (
   input  exvaf_pkg::exvaf_req_t req,
   output logic [7:0]            vector
);
   import exvaf_pkg::*;

   always_comb begin
      unique case (req.cause)
         EXVAF_C_ILLEGAL:   vector = `EXVAF_VEC_ILLEGAL;
         EXVAF_C_ADDR_ERR:  vector = `EXVAF_VEC_ADDR_ERR;
         EXVAF_C_DIV_ZERO:  vector = `EXVAF_VEC_DIV_ZERO;
         EXVAF_C_BOUNDS:    vector = `EXVAF_VEC_BOUNDS;
         EXVAF_C_COND_TRAP: vector = `EXVAF_VEC_COND_TRAP;
         EXVAF_C_PRIV:      vector = `EXVAF_VEC_PRIV;
         EXVAF_C_TRACE:     vector = `EXVAF_VEC_TRACE;
         EXVAF_C_LINE_A:    vector = `EXVAF_VEC_LINE_A;
         EXVAF_C_LINE_F:    vector = `EXVAF_VEC_LINE_F;
         EXVAF_C_FORMAT:    vector = `EXVAF_VEC_FORMAT;
         EXVAF_C_UNINIT:    vector = `EXVAF_VEC_UNINIT;
         EXVAF_C_SPURIOUS:  vector = `EXVAF_VEC_SPURIOUS;
         // level 0 is no interrupt; treat as spurious
         EXVAF_C_AUTOVEC:   vector = `EXVAF_VEC_AUTO_BASE + {5'h00, req.level};
         EXVAF_C_SW_TRAP:   vector = `EXVAF_VEC_TRAP_BASE + {4'h0, req.trap_n};
         // a requester vector below the user area would alias internal causes
         EXVAF_C_USER_INT:  vector = req.user_vec[7:6] != 2'b00 ? req.user_vec
                                                                : `EXVAF_VEC_UNINIT;
         EXVAF_C_ACCESS:    vector = `EXVAF_VEC_ACCESS;
      endcase
   end

endmodule
